// ### bcr_top.sv
// Boost control decode, slew storage and serial readback engine
module bcr_top #(
	parameter int          N_CH     = 4,
	parameter logic [7:0]  CRC_POLY = 8'h07
) (
	input  wire logic                        sys_clk,
	input  wire logic                        srst,
	input  wire logic                        sclk,
	input  wire logic                        sdin,
	input  wire logic                        sync_n,
	input  wire logic                        device_addr_hi,
	input  wire logic                        device_addr_lo,
	output logic                             sdo_q,
	output logic                             sdo_oe_q,
	output bcr_pkg::bcr_boost_cfg_t          boost_cfg_q,
	output logic      [2*N_CH-1:0]           phase_q,
	output logic      [bcr_pkg::DIV_W-1:0]   div_q,
	output logic      [N_CH-1:0]             slew_en_q,
	output logic      [N_CH-1:0][15:0]       slew_words_q,
	output logic                             crc_packet_check_q
);

	// Phasing table only covers four converters
	if (N_CH != 4) begin : g_size_chk
		$error("bcr_top: phasing logic serves four channels");
	end

	// ==========================================
	// Helpers
	function automatic logic [7:0] crc8(input logic [23:0] d);
		logic [7:0] c;
		logic       fb;
		c = 8'h00;
		for (int i = 23; i >= 0; i--) begin
			fb = c[7] ^ d[i];
			c = {c[6:0], 1'b0};
			if (fb)
				c = c ^ CRC_POLY;
		end
		return c;
	endfunction

	// edge offsets per channel, D C B A
	function automatic logic [7:0] phase_map(input logic [1:0] p);
		case (p)
			2'h0:    phase_map = {bcr_pkg::Q0, bcr_pkg::Q0,
			                      bcr_pkg::Q0, bcr_pkg::Q0};
			2'h1:    phase_map = {bcr_pkg::Q2, bcr_pkg::Q2,
			                      bcr_pkg::Q0, bcr_pkg::Q0};
			2'h2:    phase_map = {bcr_pkg::Q2, bcr_pkg::Q0,
			                      bcr_pkg::Q2, bcr_pkg::Q0};
			default: phase_map = {bcr_pkg::Q3, bcr_pkg::Q2,
			                      bcr_pkg::Q1, bcr_pkg::Q0};
		endcase
	endfunction

	// ==========================================
	// Serial frame state
	bcr_pkg::bcr_state_t state_q, state_d;
	logic        sclk_q, sclk_d;
	logic [5:0]  cnt_q, cnt_d;
	logic [31:0] in_q, in_d;
	logic [31:0] out_q, out_d;
	logic        pend_q, pend_d;
	logic [4:0]  sel_q, sel_d;
	logic        crc_q, crc_d;
	logic [15:0] boost_q, boost_d;
	logic        sdo_d, sdo_oe_d;
	logic        slew_wr;
	logic [1:0]  slew_idx;
	logic [15:0] slew_rd;
	logic [N_CH-1:0][15:0] slew_words;
	logic        sclk_fall, sclk_rise;
	logic [23:0] word;
	logic [15:0] rb_data;
	logic [23:0] rb_word;

	assign sclk_fall = sclk_q & ~sclk;
	assign sclk_rise = ~sclk_q & sclk;

	bcr_slew_bank #(
		.N_CH (N_CH),
		.W    (bcr_pkg::DATA_W)
	) u_slew (
		.sys_clk   (sys_clk),
		.srst      (srst),
		.wr_en     (slew_wr),
		.wr_idx    (slew_idx),
		.wr_data   (word[15:0]),
		.rd_idx    (sel_q[1:0]),
		.rd_data_q (slew_rd),
		.words_q   (slew_words)
	);

	// Readback source for the pending select
	always_comb begin
		rb_data = 16'h0000;
		if (sel_q >= bcr_pkg::RD_SLEW0 && sel_q <= bcr_pkg::RD_SLEW3)
			rb_data = slew_rd;
		else if (sel_q == bcr_pkg::RD_BOOST)
			rb_data = boost_q;
		else if (sel_q == bcr_pkg::RD_STATUS)
			rb_data[bcr_pkg::ST_CRC_BIT] = crc_q;
		rb_word = {8'h00, rb_data};
	end

	// ==========================================
	// Frame next state
	always_comb begin
		state_d  = state_q;
		sclk_d   = sclk;
		cnt_d    = cnt_q;
		in_d     = in_q;
		out_d    = out_q;
		pend_d   = pend_q;
		sel_d    = sel_q;
		crc_d    = crc_q;
		boost_d  = boost_q;
		sdo_oe_d = 1'b0;
		slew_wr  = 1'b0;
		slew_idx = 2'h0;
		// Packet checking frames carry the word ahead of the check byte
		word = crc_q ? in_q[31:8] : in_q[23:0];
		case (state_q)
			bcr_pkg::BCR_IDLE: begin
				if (!sync_n) begin
					state_d  = bcr_pkg::BCR_SHIFT;
					cnt_d    = 6'h00;
					sdo_oe_d = 1'b1;
					if (pend_q)
						out_d = {rb_word, crc_q ? crc8(rb_word) : 8'h00};
					else
						out_d = 32'h0000_0000;
				end
			end
			bcr_pkg::BCR_SHIFT: begin
				sdo_oe_d = 1'b1;
				if (sclk_fall) begin
					in_d  = {in_q[30:0], sdin};
					cnt_d = cnt_q + 6'h01;
				end
				if (sclk_rise && cnt_q != 6'h00)
					out_d = {out_q[30:0], 1'b0};
				if (sync_n) begin
					state_d  = bcr_pkg::BCR_IDLE;
					sdo_oe_d = 1'b0;
					// Short or long frames are dropped whole
					if (cnt_q == (crc_q ? bcr_pkg::CNT_CRC
					                    : bcr_pkg::CNT_PLAIN)) begin
						pend_d = 1'b0;
						if (word[bcr_pkg::ADH_BIT] == device_addr_hi &&
						    word[bcr_pkg::ADL_BIT] == device_addr_lo) begin
							if (word[bcr_pkg::RW_BIT]) begin
								pend_d = 1'b1;
								sel_d  = word[bcr_pkg::RD_HI:bcr_pkg::RD_LO];
							end else if (word[bcr_pkg::REG_HI:bcr_pkg::REG_LO]
							             == bcr_pkg::REG_CTRL) begin
								case (word[bcr_pkg::SUB_HI:bcr_pkg::SUB_LO])
									bcr_pkg::SUB_BOOST: boost_d = word[15:0];
									bcr_pkg::SUB_SLEW: begin
										slew_wr  = 1'b1;
										slew_idx = word[bcr_pkg::CH_HI:bcr_pkg::CH_LO];
									end
									bcr_pkg::SUB_SOFT:
										crc_d = word[bcr_pkg::CRC_EN_BIT];
									default: ;
								endcase
							end
						end
					end
				end
			end
			default: state_d = bcr_pkg::BCR_IDLE;
		endcase
		sdo_d = out_d[31];
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_q  <= bcr_pkg::BCR_IDLE;
			sclk_q   <= 1'b0;
			cnt_q    <= 6'h00;
			in_q     <= 32'h0000_0000;
			out_q    <= 32'h0000_0000;
			pend_q   <= 1'b0;
			sel_q    <= 5'h00;
			crc_q    <= 1'b0;
			boost_q  <= bcr_pkg::BOOST_RST;
			sdo_q    <= 1'b0;
			sdo_oe_q <= 1'b0;
		end else begin
			state_q  <= state_d;
			sclk_q   <= sclk_d;
			cnt_q    <= cnt_d;
			in_q     <= in_d;
			out_q    <= out_d;
			pend_q   <= pend_d;
			sel_q    <= sel_d;
			crc_q    <= crc_d;
			boost_q  <= boost_d;
			sdo_q    <= sdo_d;
			sdo_oe_q <= sdo_oe_d;
		end
	end

	// ==========================================
	// Decoded settings
	bcr_pkg::bcr_boost_cfg_t cfg_d;
	logic [2*N_CH-1:0]       phase_d;
	logic [5:0]              div_d;
	logic [N_CH-1:0]         slew_en_d;

	// Reset shows the default word, not all zeros
	localparam bcr_pkg::bcr_boost_cfg_t CFG_RST =
		bcr_pkg::bcr_boost_cfg_t'(
		bcr_pkg::BOOST_RST[bcr_pkg::COMP_BIT:bcr_pkg::MV_LO]);

	always_comb begin
		// comp select straight from its bit
		cfg_d.comp_ext = boost_q[bcr_pkg::COMP_BIT];
		cfg_d.phasing  = boost_q[bcr_pkg::PH_HI:bcr_pkg::PH_LO];
		cfg_d.rate     = boost_q[bcr_pkg::FR_HI:bcr_pkg::FR_LO];
		cfg_d.ceiling  = boost_q[bcr_pkg::MV_HI:bcr_pkg::MV_LO];
		phase_d = phase_map(cfg_d.phasing);
		case (cfg_d.rate)
			2'h0:    div_d = bcr_pkg::DIV0;
			2'h2:    div_d = bcr_pkg::DIV2;
			default: div_d = bcr_pkg::DIV1;
		endcase
		for (int i = 0; i < N_CH; i++)
			slew_en_d[i] = slew_words[i][bcr_pkg::SLEW_EN_BIT];
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			boost_cfg_q        <= CFG_RST;
			phase_q            <= '0;
			div_q              <= bcr_pkg::DIV1;
			slew_en_q          <= '0;
			slew_words_q       <= '0;
			crc_packet_check_q <= 1'b0;
		end else begin
			boost_cfg_q        <= cfg_d;
			phase_q            <= phase_d;
			div_q              <= div_d;
			slew_en_q          <= slew_en_d;
			slew_words_q       <= slew_words;
			crc_packet_check_q <= crc_q;
		end
	end

endmodule

// ### bcr_pkg.sv
// Constants and types for boost configuration and readback
package bcr_pkg;

	// ==========================================
	// Serial frame layout
	localparam int            WORD_W     = 24;
	localparam int            DATA_W     = 16;
	localparam int            PAD_W      = 8;
	localparam int            CRC_W      = 8;
	localparam int            FRAME_W    = 32;
	localparam logic [5:0]    CNT_PLAIN  = 6'h18;
	localparam logic [5:0]    CNT_CRC    = 6'h20;
	localparam int            RW_BIT     = 23;
	localparam int            ADH_BIT    = 22;
	localparam int            ADL_BIT    = 21;
	localparam int            RD_HI      = 20;
	localparam int            RD_LO      = 16;
	localparam int            REG_HI     = 20;
	localparam int            REG_LO     = 18;
	localparam int            CH_HI      = 17;
	localparam int            CH_LO      = 16;
	localparam int            SUB_HI     = 15;
	localparam int            SUB_LO     = 13;
	localparam int            CRC_EN_BIT = 12;

	// ==========================================
	// Write routing codes
	localparam logic [2:0]    REG_CTRL   = 3'h7;
	localparam logic [2:0]    SUB_SLEW   = 3'h0;
	localparam logic [2:0]    SUB_BOOST  = 3'h3;
	localparam logic [2:0]    SUB_SOFT   = 3'h4;

	// ==========================================
	// Read select codes
	localparam logic [4:0]    RD_SLEW0   = 5'h14;
	localparam logic [4:0]    RD_SLEW3   = 5'h17;
	localparam logic [4:0]    RD_STATUS  = 5'h18;
	localparam logic [4:0]    RD_BOOST   = 5'h1a;
	localparam int            ST_CRC_BIT = 11;

	// ==========================================
	// Boost control word fields, then slew word reset value and enable bit
	localparam int            COMP_BIT   = 6;
	localparam int            PH_HI      = 5;
	localparam int            PH_LO      = 4;
	localparam int            FR_HI      = 3;
	localparam int            FR_LO      = 2;
	localparam int            MV_HI      = 1;
	localparam int            MV_LO      = 0;
	localparam logic [15:0]   BOOST_RST  = 16'h0004;
	localparam logic [15:0]   SLEW_RST   = 16'h0000;
	localparam int            SLEW_EN_BIT = 12;

	// ==========================================
	// Switching rate divider from the oscillator
	localparam int            OSC_KHZ    = 13000;
	localparam int            RATE0_KHZ  = 250;
	localparam int            RATE1_KHZ  = 410;
	localparam int            RATE2_KHZ  = 650;
	localparam int            DIV_W      = 6;
	localparam logic [5:0]    DIV0 = 6'((OSC_KHZ + RATE0_KHZ / 2) / RATE0_KHZ);
	localparam logic [5:0]    DIV1 = 6'((OSC_KHZ + RATE1_KHZ / 2) / RATE1_KHZ);
	localparam logic [5:0]    DIV2 = 6'((OSC_KHZ + RATE2_KHZ / 2) / RATE2_KHZ);

	// Quarter-period offsets per channel
	localparam logic [1:0]    Q0 = 2'h0;
	localparam logic [1:0]    Q1 = 2'h1;
	localparam logic [1:0]    Q2 = 2'h2;
	localparam logic [1:0]    Q3 = 2'h3;

	typedef struct packed {
		logic       comp_ext;
		logic [1:0] phasing;
		logic [1:0] rate;
		logic [1:0] ceiling;
	} bcr_boost_cfg_t;

	typedef enum logic [1:0] {
		BCR_IDLE  = 2'b01,
		BCR_SHIFT = 2'b10
	} bcr_state_t;

endpackage

// ### bcr_slew_bank.sv
// Per-channel slew control word storage with registered read
module bcr_slew_bank #(
	parameter int N_CH = 4,
	parameter int W    = 16
) (
	input  wire logic                          sys_clk,
	input  wire logic                          srst,
	input  wire logic                          wr_en,
	input  wire logic [$clog2(N_CH)-1:0]       wr_idx,
	input  wire logic [W-1:0]                  wr_data,
	input  wire logic [$clog2(N_CH)-1:0]       rd_idx,
	output logic      [W-1:0]                  rd_data_q,
	output logic      [N_CH-1:0][W-1:0]        words_q
);

	// Index width and word width are fixed by the frame layout
	if (N_CH < 2 || W != bcr_pkg::DATA_W) begin : g_size_chk
		$error("bcr_slew_bank: unsupported size");
	end

	logic [N_CH-1:0][W-1:0] words_d;
	logic [W-1:0]           rd_data_d;

	// ==========================================
	// Next state
	always_comb begin
		words_d = words_q;
		if (wr_en)
			words_d[wr_idx] = wr_data;
		rd_data_d = words_q[rd_idx];
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			words_q   <= {N_CH{bcr_pkg::SLEW_RST}};
			rd_data_q <= bcr_pkg::SLEW_RST;
		end else begin
			words_q   <= words_d;
			rd_data_q <= rd_data_d;
		end
	end

endmodule

// ### bcr_host.sv
// Serial host model driving the frame, clock and data lines
module bcr_host (
	input  wire logic sys_clk,
	input  wire logic sdo_q,
	output logic      sclk,
	output logic      sdin,
	output logic      sync_n
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		sclk = 1'b0;
		sdin = 1'b0;
		sync_n = 1'b1;
	end

	task automatic tick(input int k);
		repeat (k) @(negedge sys_clk);
	endtask

	task automatic xfer(input logic [31:0] w, input int n,
			output logic [31:0] r);
		r = '0;
		sync_n = 1'b0;
		tick(2);
		for (int i = n - 1; i >= 0; i--) begin
			sdin = w[i];
			sclk = 1'b1;
			tick(2);
			r = {r[30:0], sdo_q};
			sclk = 1'b0;
			tick(2);
		end
		sync_n = 1'b1;
		// Released line must not look held
		sdin = ~sdin;
		tick(4);
	endtask
endmodule

// ### bcr_top_checker.sv
// Port checker for boost configuration and readback
module bcr_chk #(
	parameter int N_CH = 4
) (
	input wire logic                        sys_clk,
	input wire logic                        srst,
	input wire logic                        sclk,
	input wire logic                        sync_n,
	input wire logic                        sdo_q,
	input wire logic                        sdo_oe_q,
	input wire bcr_pkg::bcr_boost_cfg_t     boost_cfg_q,
	input wire logic [2*N_CH-1:0]           phase_q,
	input wire logic [bcr_pkg::DIV_W-1:0]   div_q,
	input wire logic [N_CH-1:0]             slew_en_q,
	input wire logic [N_CH-1:0][15:0]       slew_words_q,
	input wire logic                        crc_packet_check_q
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0]                up_q;
	logic [1:0]                up_d;
	logic [2*N_CH-1:0]         ph_exp;
	logic [bcr_pkg::DIV_W-1:0] dv_exp;
	logic [N_CH-1:0]           en_exp;

	always_comb begin
		up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
		case (boost_cfg_q.phasing)
			2'h0: ph_exp = 8'h00;
			2'h1: ph_exp = 8'hA0;
			2'h2: ph_exp = 8'h88;
			default: ph_exp = 8'hE4;
		endcase
		case (boost_cfg_q.rate)
			2'h0: dv_exp = bcr_pkg::DIV0;
			2'h2: dv_exp = bcr_pkg::DIV2;
			default: dv_exp = bcr_pkg::DIV1;
		endcase
		for (int i = 0; i < N_CH; i++)
			en_exp[i] = slew_words_q[i][12];
	end

	// Settle window after reset
	always_ff @(posedge sys_clk) begin
		up_q <= srst ? 2'h0 : up_d;
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);

	property p_oe_start;
		$fell(sync_n) && !sdo_oe_q |-> ##[1:2] sdo_oe_q;
	endproperty
	a_oe_start: assert property (p_oe_start)
		else $error("frame start not seen");
	property p_oe_end;
		$rose(sync_n) |-> ##[1:2] !sdo_oe_q;
	endproperty
	a_oe_end: assert property (p_oe_end)
		else $error("output enable stuck");
	property p_div;
		(up_q == 2'h3 && $stable(boost_cfg_q))[*2] |-> div_q == dv_exp;
	endproperty
	a_div: assert property (p_div)
		else $error("divider mismatch");
	property p_phase;
		(up_q == 2'h3 && $stable(boost_cfg_q))[*2] |-> phase_q == ph_exp;
	endproperty
	a_phase: assert property (p_phase)
		else $error("phasing mismatch");
	property p_slew_en;
		(up_q == 2'h3 && $stable(slew_words_q) && $stable(slew_en_q))[*2]
			|-> slew_en_q == en_exp;
	endproperty
	a_slew_en: assert property (p_slew_en)
		else $error("slew enable mismatch");
	property p_cfg_hold;
		up_q == 2'h3 && $changed(boost_cfg_q) |-> sync_n;
	endproperty
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("config changed mid frame");
	property p_crc_hold;
		up_q == 2'h3 && $changed(crc_packet_check_q) |-> sync_n;
	endproperty
	a_crc_hold: assert property (p_crc_hold)
		else $error("check enable changed mid frame");
	property p_sdo;
		$changed(sdo_q) && sdo_oe_q && $past(sdo_oe_q)
			|-> $past(sclk) || $past(sclk, 2);
	endproperty
	a_sdo: assert property (p_sdo)
		else $error("output bit moved without clock");

	c_rate3: cover property (boost_cfg_q.rate == 2'h3);
	c_crc: cover property (crc_packet_check_q);
	c_frame: cover property ($rose(sdo_oe_q));
endmodule

bind bcr_top bcr_chk #(.N_CH(N_CH)) chk_u (
	.sys_clk(sys_clk), .srst(srst), .sclk(sclk), .sync_n(sync_n),
	.sdo_q(sdo_q), .sdo_oe_q(sdo_oe_q), .boost_cfg_q(boost_cfg_q),
	.phase_q(phase_q), .div_q(div_q), .slew_en_q(slew_en_q),
	.slew_words_q(slew_words_q), .crc_packet_check_q(crc_packet_check_q)
);

// ### tb.sv
// Self-checking bench for boost configuration and readback
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [1:0] ADDR = 2'h1;
	logic                    sys_clk, srst, sclk, sdin, sync_n;
	logic                    sdo_q, sdo_oe_q, crc_packet_check_q, crc_packet_check;
	logic [1:0]              adr;
	bcr_pkg::bcr_boost_cfg_t boost_cfg_q;
	logic [7:0]              phase_q;
	logic [5:0]              div_q;
	logic [3:0]              slew_en_q;
	logic [3:0][15:0]        slew_words_q;
	logic [31:0]             r;
	logic [15:0]             d;
	int                      err_total, checks_done;
	logic [7:0]              ph_t [4] = '{8'h00, 8'hA0, 8'h88, 8'hE4};
	logic [5:0]              dv_t [4] = '{bcr_pkg::DIV0, bcr_pkg::DIV1,
		bcr_pkg::DIV2, bcr_pkg::DIV1};

	bcr_top dut_u (.sys_clk(sys_clk), .srst(srst), .sclk(sclk),
		.sdin(sdin), .sync_n(sync_n), .device_addr_hi(adr[1]),
		.device_addr_lo(adr[0]), .sdo_q(sdo_q), .sdo_oe_q(sdo_oe_q),
		.boost_cfg_q(boost_cfg_q), .phase_q(phase_q), .div_q(div_q),
		.slew_en_q(slew_en_q), .slew_words_q(slew_words_q),
		.crc_packet_check_q(crc_packet_check_q));
	bcr_host host_u (.sys_clk(sys_clk), .sdo_q(sdo_q), .sclk(sclk),
		.sdin(sdin), .sync_n(sync_n));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic cmp(input string nm, input logic [15:0] e,
			input logic [15:0] s);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	function automatic logic [7:0] crc8(input logic [23:0] v);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction

	function automatic logic [15:0] sw(input int c);
		return {3'b000, c[0], 8'h0A, 2'b00, c[1:0]};
	endfunction

	task automatic xf(input logic [23:0] w);
		host_u.xfer(crc_packet_check ? {w, 8'h00} : {8'h00, w}, crc_packet_check ? 32 : 24, r);
	endtask

	task automatic wr(input logic [1:0] ch, input logic [15:0] v);
		xf({1'b0, ADDR, 3'b111, ch, v});
	endtask

	task automatic get(input logic [4:0] sel, output logic [15:0] v);
		xf({1'b1, ADDR, sel, 16'h0000});
		xf(24'h3CE000);
		v = crc_packet_check ? r[23:8] : r[15:0];
		cmp("pad", 16'h0000, crc_packet_check ? 16'(r[31:24]) : 16'(r[23:16]));
		if (crc_packet_check)
			cmp("crc", 16'(crc8({8'h00, v})), 16'(r[7:0]));
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		err_total++;
		tally_and_finish();
	end

	initial begin
		err_total = 0;
		checks_done = 0;
		crc_packet_check = 1'b0;
		adr = ADDR;
		srst = 1'b1;
		repeat (12) @(negedge sys_clk);
		srst = 1'b0;
		repeat (3) @(negedge sys_clk);
		cmp("cfg", 16'h0004, 16'(boost_cfg_q));
		cmp("div", 16'(bcr_pkg::DIV1), 16'(div_q));
		cmp("phase", 16'h0000, 16'(phase_q));
		get(bcr_pkg::RD_BOOST, d);
		cmp("rdboost", 16'h0004, d);
		for (int i = 0; i < 4; i++) begin
			wr(2'h0, {3'b011, 6'h00, i[0], i[1:0], i[1:0], i[1:0]});
			cmp("cfg", 16'({i[0], i[1:0], i[1:0], i[1:0]}),
				16'(boost_cfg_q));
			cmp("phase", 16'(ph_t[i]), 16'(phase_q));
			cmp("div", 16'(dv_t[i]), 16'(div_q));
			get(bcr_pkg::RD_BOOST, d);
			cmp("rdboost", 16'({i[0], i[1:0], i[1:0], i[1:0]}),
				d & 16'h007F);
		end
		adr = 2'h2;
		wr(2'h0, 16'h6000);
		adr = ADDR;
		host_u.xfer(32'h00FC_6000, 23, r);
		cmp("ignored", 16'h007F, 16'(boost_cfg_q));
		get(5'h00, d);
		cmp("rdother", 16'h0000, d);
		for (int c = 0; c < 4; c++) begin
			wr(2'(c), sw(c));
			cmp("slew", sw(c), slew_words_q[c]);
			cmp("slewen", 16'(c[0]), 16'(slew_en_q[c]));
		end
		xf({1'b1, ADDR, bcr_pkg::RD_SLEW0, 16'h0000});
		for (int c = 1; c < 4; c++) begin
			xf({1'b1, ADDR, bcr_pkg::RD_SLEW0 + 5'(c), 16'h0000});
			cmp("rdslew", sw(c - 1), r[15:0]);
		end
		xf(24'h3CE000);
		cmp("rdslew", sw(3), r[15:0]);
		wr(2'h0, 16'h9000);
		crc_packet_check = 1'b1;
		cmp("pecon", 16'h0001, 16'(crc_packet_check_q));
		get(bcr_pkg::RD_STATUS, d);
		cmp("stat", 16'h0001, 16'(d[bcr_pkg::ST_CRC_BIT]));
		get(bcr_pkg::RD_SLEW3, d);
		cmp("rdslew", sw(3), d);
		wr(2'h0, 16'h8000);
		crc_packet_check = 1'b0;
		cmp("pecoff", 16'h0000, 16'(crc_packet_check_q));
		get(bcr_pkg::RD_BOOST, d);
		cmp("rdboost", 16'h007F, d & 16'h007F);
		tally_and_finish();
	end
endmodule
